// ===== design/orpm_map.svh
// Register offsets, field positions, reset values and timing counts for
// the output ramp and power mode controller.
// Assumes a 25 MHz core clock and a simple byte-wide register port.
`ifndef ORPM_MAP_SVH
`define ORPM_MAP_SVH

// Register offsets
`define ORPM_ADDR_TARGET0 8'h08
`define ORPM_ADDR_TARGET1 8'h0a
`define ORPM_ADDR_TARGET2 8'h0c
`define ORPM_ADDR_TARGET3 8'h0e
`define ORPM_ADDR_RAMP_CTRL 8'h10
`define ORPM_ADDR_STEP_CFG 8'h11
`define ORPM_ADDR_GLOBAL_CFG 8'h12
`define ORPM_ADDR_OVL_STATE 8'h13
`define ORPM_ADDR_OVL_FLAG 8'h14

// Field positions
`define ORPM_BIT_RAMP_RATE 5
`define ORPM_BIT_FAST_START 4
`define ORPM_BIT_BIAS_LP 0
`define ORPM_BIT_INNER_OFF 1

// Reset values
`define ORPM_RST_RAMP_CTRL 8'h00
`define ORPM_RST_TARGET 8'h00
`define ORPM_RST_STEP_CFG 8'h00
`define ORPM_RST_GLOBAL_CFG 8'h00

// Overload threshold in valley current steps (150mA each, 1.2A max)
`define ORPM_VALLEY_MAX 4'h8

// Timing: clock period, slopes, step sizes, latencies
`define ORPM_CLK_PERIOD_NS 40
`define ORPM_SLOPE_RISE_UVUS 2000
`define ORPM_SLOPE_SLOW_UVUS 5000
`define ORPM_SLOPE_FAST_UVUS 10000
`define ORPM_STEP_COARSE_UV 25000
`define ORPM_STEP_FINE_UV 12500
`define ORPM_LAT_SLOW_US 100
`define ORPM_LAT_FAST_US 10
`define ORPM_LAT_SLOW_CYC \
   ((`ORPM_LAT_SLOW_US * 1000) / `ORPM_CLK_PERIOD_NS)
`define ORPM_LAT_FAST_CYC \
   ((`ORPM_LAT_FAST_US * 1000) / `ORPM_CLK_PERIOD_NS)
// Cycles per code step; rounded down so the slope is never slower
`define ORPM_STEP_CYC(stepuv, slope) \
   (((stepuv) * 1000 / (slope)) / `ORPM_CLK_PERIOD_NS)

`endif

// ===== design/orpm_pkg.sv
// Types shared by the output ramp and power mode controller.
// Assumes orpm_map.svh supplies all numeric constants.
package orpm_pkg;

   // Per-channel ramp sequencer states
   typedef enum logic [1:0] {
      ORPM_IDLE = 2'b00,
      ORPM_WAIT = 2'b01,
      ORPM_RAMP = 2'b10
   } orpm_ramp_state_e;

   // Decoded bias power mode
   typedef enum logic [1:0] {
      ORPM_PM_NORMAL = 2'b00,
      ORPM_PM_LOW = 2'b01,
      ORPM_PM_PARTIAL = 2'b10
   } orpm_pmode_e;

   // Ramp configuration seen by one channel
   typedef struct packed {
      logic riseSel;
      logic fastStart;
      logic rateFast;
      logic stepFine;
   } orpm_chan_cfg_s;

endpackage

// ===== design/orpm_ramp_chan.sv
// One channel's voltage reference ramp sequencer.
// Assumes targetWr is a one-cycle pulse with targetCode valid beside it.
`timescale 1ns/100ps
`include "orpm_map.svh"

module orpm_ramp_chan
   import orpm_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Target update and configuration
   input wire logic [7:0] targetCode,
   input wire logic targetWr,
   input wire orpm_chan_cfg_s cfg,
   // Reference state
   output logic [7:0] refCode,
   output logic ramping
);

   localparam logic [11:0] LatSlow = 12'(`ORPM_LAT_SLOW_CYC);
   localparam logic [11:0] LatFast = 12'(`ORPM_LAT_FAST_CYC);
   localparam logic [11:0] CycCR = 12'(`ORPM_STEP_CYC(`ORPM_STEP_COARSE_UV,
      `ORPM_SLOPE_RISE_UVUS));
   localparam logic [11:0] CycCS = 12'(`ORPM_STEP_CYC(`ORPM_STEP_COARSE_UV,
      `ORPM_SLOPE_SLOW_UVUS));
   localparam logic [11:0] CycCF = 12'(`ORPM_STEP_CYC(`ORPM_STEP_COARSE_UV,
      `ORPM_SLOPE_FAST_UVUS));
   localparam logic [11:0] CycFR = 12'(`ORPM_STEP_CYC(`ORPM_STEP_FINE_UV,
      `ORPM_SLOPE_RISE_UVUS));
   localparam logic [11:0] CycFS = 12'(`ORPM_STEP_CYC(`ORPM_STEP_FINE_UV,
      `ORPM_SLOPE_SLOW_UVUS));
   localparam logic [11:0] CycFF = 12'(`ORPM_STEP_CYC(`ORPM_STEP_FINE_UV,
      `ORPM_SLOPE_FAST_UVUS));

   orpm_ramp_state_e state_r;
   logic [7:0] goal_r;
   logic [11:0] count_r;
   logic [11:0] stepCyc;
   logic [11:0] latCyc;

   // Cycles per code step from slope and step size
   always_comb begin
      if (!cfg.riseSel) begin
         stepCyc = cfg.stepFine ? CycFR : CycCR;
      end else if (cfg.rateFast) begin
         stepCyc = cfg.stepFine ? CycFF : CycCF;
      end else begin
         stepCyc = cfg.stepFine ? CycFS : CycCS;
      end
   end

   // Fast start only counts when the channel uses the global slope
   assign latCyc = (cfg.fastStart && cfg.riseSel) ? LatFast : LatSlow;

   assign ramping = (state_r != ORPM_IDLE);

   // Sequencer: latency wait, then one code per step interval
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_r <= ORPM_IDLE;
         goal_r <= `ORPM_RST_TARGET;
         refCode <= `ORPM_RST_TARGET;
         count_r <= 12'h000;
      end else if (targetWr) begin
         goal_r <= targetCode;
         if (targetCode > refCode) begin
            // A rewrite mid-ramp restarts the latency from here
            state_r <= ORPM_WAIT;
            count_r <= latCyc - 12'h001;
         end else begin
            refCode <= targetCode;
            state_r <= ORPM_IDLE;
            count_r <= 12'h000;
         end
      end else begin
         unique case (state_r)
            ORPM_IDLE: begin
               count_r <= 12'h000;
            end
            ORPM_WAIT: begin
               if (count_r == 12'h000) begin
                  state_r <= ORPM_RAMP;
                  count_r <= stepCyc - 12'h001;
               end else begin
                  count_r <= count_r - 12'h001;
               end
            end
            ORPM_RAMP: begin
               if (refCode >= goal_r) begin
                  state_r <= ORPM_IDLE;
               end else if (count_r == 12'h000) begin
                  refCode <= refCode + 8'h01;
                  count_r <= stepCyc - 12'h001;
                  if (refCode + 8'h01 == goal_r) begin
                     state_r <= ORPM_IDLE;
                  end
               end else begin
                  count_r <= count_r - 12'h001;
               end
            end
            default: begin
               state_r <= ORPM_IDLE;
            end
         endcase
      end
   end

endmodule

// ===== design/orpm_ctrl.sv
// Top of the output ramp and power mode controller: register file,
// power mode decode, overload tracking and four ramp sequencers.
// Assumes a synchronous byte-wide register port driven by the serial
// interface logic, and valley current steps from the analog loop.
`timescale 1ns/100ps
`include "orpm_map.svh"

module orpm_ctrl
   import orpm_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register port
   input wire logic regWrEn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   // Analog loop status
   input wire logic [3:0] valleySteps,
   input wire logic [3:0] chanServiced,
   // Reference codes and ramp activity
   output logic [7:0] refCode0,
   output logic [7:0] refCode1,
   output logic [7:0] refCode2,
   output logic [7:0] refCode3,
   output logic [3:0] chanRamping,
   // Power mode controls
   output logic biasLowPower,
   output logic sectionsLowPower,
   output orpm_pmode_e powerMode,
   output logic fastStartActive
);

   ////////////////////////////////////////////////////////////////////////
   // Register storage

   logic [7:0] rampCtrl_r;
   logic [3:0] stepCfg_r;
   logic [1:0] globalCfg_r;
   logic [3:0] ovlState_r;
   logic [3:0] ovlFlag_r;
   logic [7:0] target_r [4];
   logic [3:0] targetWr;
   logic [7:0] refCode [4];

   // Target write strobes, one per channel
   always_comb begin
      targetWr[0] = regWrEn && (regAddr == `ORPM_ADDR_TARGET0);
      targetWr[1] = regWrEn && (regAddr == `ORPM_ADDR_TARGET1);
      targetWr[2] = regWrEn && (regAddr == `ORPM_ADDR_TARGET2);
      targetWr[3] = regWrEn && (regAddr == `ORPM_ADDR_TARGET3);
   end

   // Ramp control register, bits 7:6 reserved and read zero
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rampCtrl_r <= `ORPM_RST_RAMP_CTRL;
      end else if (regWrEn && regAddr == `ORPM_ADDR_RAMP_CTRL) begin
         rampCtrl_r <= {2'b00, regWrData[5:0]};
      end
   end

   // Step size and global configuration
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         stepCfg_r <= 4'(`ORPM_RST_STEP_CFG);
         globalCfg_r <= 2'(`ORPM_RST_GLOBAL_CFG);
      end else if (regWrEn) begin
         if (regAddr == `ORPM_ADDR_STEP_CFG) begin
            stepCfg_r <= regWrData[3:0];
         end
         if (regAddr == `ORPM_ADDR_GLOBAL_CFG) begin
            globalCfg_r <= regWrData[1:0];
         end
      end
   end

   // Target codes held for readback
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         for (int i = 0; i < 4; i++) begin
            target_r[i] <= `ORPM_RST_TARGET;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (targetWr[i]) begin
               target_r[i] <= regWrData;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Overload tracking

   logic overloadNow;
   assign overloadNow = (valleySteps >= `ORPM_VALLEY_MAX);

   // Live state follows the loop; flags stick, set beats a W1C clear
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ovlState_r <= 4'h0;
         ovlFlag_r <= 4'h0;
      end else begin
         ovlState_r <= {4{overloadNow}} & chanServiced;
         if (regWrEn && regAddr == `ORPM_ADDR_OVL_FLAG) begin
            ovlFlag_r <= (ovlFlag_r & ~regWrData[3:0]) |
               ({4{overloadNow}} & chanServiced);
         end else begin
            ovlFlag_r <= ovlFlag_r |
               ({4{overloadNow}} & chanServiced);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power mode decode

   logic biasLp;
   logic innerOff;
   assign biasLp = globalCfg_r[`ORPM_BIT_BIAS_LP];
   assign innerOff = globalCfg_r[`ORPM_BIT_INNER_OFF];

   // Held in flops; the mode bits are meant to change only at rest
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         biasLowPower <= 1'b0;
         sectionsLowPower <= 1'b0;
         powerMode <= ORPM_PM_NORMAL;
      end else if (!biasLp) begin
         biasLowPower <= 1'b0;
         sectionsLowPower <= 1'b0;
         powerMode <= ORPM_PM_NORMAL;
      end else if (!innerOff) begin
         biasLowPower <= 1'b1;
         sectionsLowPower <= 1'b1;
         powerMode <= ORPM_PM_LOW;
      end else begin
         biasLowPower <= 1'b0;
         sectionsLowPower <= 1'b1;
         powerMode <= ORPM_PM_PARTIAL;
      end
   end

   // Fast start costs quiescent current; shown for the bias sequencer
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         fastStartActive <= 1'b0;
      end else begin
         fastStartActive <= rampCtrl_r[`ORPM_BIT_FAST_START] &&
            (rampCtrl_r[3:0] != 4'h0);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Ramp sequencers

   for (genvar ch = 0; ch < 4; ch++) begin : gChan
      orpm_chan_cfg_s cfg;
      always_comb begin
         cfg.riseSel = rampCtrl_r[ch];
         cfg.fastStart = rampCtrl_r[`ORPM_BIT_FAST_START];
         cfg.rateFast = rampCtrl_r[`ORPM_BIT_RAMP_RATE];
         cfg.stepFine = stepCfg_r[ch];
      end
      orpm_ramp_chan uChan (
         .clk(clk),
         .reset_n(reset_n),
         .targetCode(regWrData),
         .targetWr(targetWr[ch]),
         .cfg(cfg),
         .refCode(refCode[ch]),
         .ramping(chanRamping[ch])
      );
   end

   assign refCode0 = refCode[0];
   assign refCode1 = refCode[1];
   assign refCode2 = refCode[2];
   assign refCode3 = refCode[3];

   ////////////////////////////////////////////////////////////////////////
   // Readback, one cycle after the address; unmapped reads zero

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         regRdData <= 8'h00;
      end else begin
         unique case (regAddr)
            `ORPM_ADDR_TARGET0: regRdData <= target_r[0];
            `ORPM_ADDR_TARGET1: regRdData <= target_r[1];
            `ORPM_ADDR_TARGET2: regRdData <= target_r[2];
            `ORPM_ADDR_TARGET3: regRdData <= target_r[3];
            `ORPM_ADDR_RAMP_CTRL: regRdData <= rampCtrl_r;
            `ORPM_ADDR_STEP_CFG: regRdData <= {4'h0, stepCfg_r};
            `ORPM_ADDR_GLOBAL_CFG: regRdData <= {6'h00, globalCfg_r};
            `ORPM_ADDR_OVL_STATE: regRdData <= {4'h0, ovlState_r};
            `ORPM_ADDR_OVL_FLAG: regRdData <= {4'h0, ovlFlag_r};
            default: regRdData <= 8'h00;
         endcase
      end
   end

endmodule

// ===== verification/orpm_ctrl_chk.sv
// Concurrent checks on the ramp and power mode controller ports.
// Assumes the map header gives the register offsets used here.
`timescale 1ns/100ps
`include "orpm_map.svh"
module orpm_ctrl_chk
   import orpm_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register port
   input wire logic regWrEn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic [7:0] regRdData,
   // Ramp and mode outputs
   input wire logic [7:0] refCode0,
   input wire logic [3:0] chanRamping,
   input wire logic biasLowPower,
   input wire logic sectionsLowPower,
   input wire orpm_pmode_e powerMode,
   input wire logic fastStartActive
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////////
   // Decoded writes; only channel 0 is watched to keep this small
   logic glbWr;
   logic rampWr;
   logic tgtWr;
   logic fastCfg;
   assign glbWr = regWrEn && regAddr == `ORPM_ADDR_GLOBAL_CFG;
   assign rampWr = regWrEn && regAddr == `ORPM_ADDR_RAMP_CTRL;
   assign tgtWr = regWrEn && regAddr == `ORPM_ADDR_TARGET0;
   assign fastCfg = regWrData[4] && |regWrData[3:0];
   ////////////////////////////////////////////////////////////////////////
   chk_mode_normal: assert property (
      glbWr && !regWrData[0] |-> ##2 powerMode == ORPM_PM_NORMAL
      && !biasLowPower && !sectionsLowPower)
      else $error("normal power mode not decoded");
   chk_mode_low: assert property (
      glbWr && regWrData[1:0] == 2'b01 |-> ##2 powerMode == ORPM_PM_LOW
      && biasLowPower && sectionsLowPower)
      else $error("low power mode not decoded");
   chk_mode_partial: assert property (
      glbWr && regWrData[1:0] == 2'b11 |-> ##2
      powerMode == ORPM_PM_PARTIAL
      && !biasLowPower && sectionsLowPower)
      else $error("partial power mode not decoded");
   chk_fast_start: assert property (
      rampWr |-> ##2 fastStartActive == $past(fastCfg, 2))
      else $error("fast start flag wrong after write");
   chk_drop_now: assert property (
      tgtWr && regWrData <= refCode0 |=> refCode0 == $past(regWrData)
      && !chanRamping[0])
      else $error("downward target not taken at once");
   chk_rise_waits: assert property (
      tgtWr && regWrData > refCode0 |=> chanRamping[0] && $stable(refCode0))
      else $error("upward target did not start a wait");
   chk_step_one: assert property (
      refCode0 > $past(refCode0) |-> refCode0 == $past(refCode0) + 8'h01
      && $past(chanRamping[0]))
      else $error("reference rose by more than one code");
   chk_unmapped_zero: assert property (
      regAddr == 8'h20 |=> regRdData == 8'h00)
      else $error("unmapped address read nonzero");
   chk_ramp_upper: assert property (
      regAddr == `ORPM_ADDR_RAMP_CTRL |=> regRdData[7:6] == 2'b00)
      else $error("ramp control upper bits nonzero");
endmodule

bind orpm_ctrl orpm_ctrl_chk u_orpm_ctrl_chk (.clk, .reset_n, .regWrEn,
   .regAddr, .regWrData, .regRdData, .refCode0, .chanRamping,
   .biasLowPower, .sectionsLowPower, .powerMode, .fastStartActive);

// ===== verification/tb.sv
// Self-checking bench for the ramp and power mode controller.
// Assumes the map header offsets and a 25 MHz clock.
`timescale 1ns/100ps
`include "orpm_map.svh"
module tb;
   import orpm_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic regWrEn = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic [3:0] valleySteps = 4'h0;
   logic [3:0] chanServiced = 4'h0;
   logic [7:0] regRdData, refCode0, refCode1, refCode2, refCode3;
   logic [3:0] chanRamping;
   logic biasLowPower, sectionsLowPower, fastStartActive;
   orpm_pmode_e powerMode;
   int errors = 0;
   int nCompared = 0;
   int cycles = 0;
   ////////////////////////////////////////////////////////////////////////
   // Clock, run ceiling about two and a half times the longest expected run
   initial forever #20 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         conclude();
      end
   end
   orpm_ctrl u_orpm_ctrl (.clk(clk), .reset_n(reset_n), .regWrEn(regWrEn),
      .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
      .valleySteps(valleySteps), .chanServiced(chanServiced),
      .refCode0(refCode0), .refCode1(refCode1), .refCode2(refCode2),
      .refCode3(refCode3), .chanRamping(chanRamping),
      .biasLowPower(biasLowPower), .sectionsLowPower(sectionsLowPower),
      .powerMode(powerMode), .fastStartActive(fastStartActive));
   ////////////////////////////////////////////////////////////////////////
   // Compare, bus and closing tasks
   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      nCompared++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Ramp timing is approximate, so allow a few cycles either way
   task automatic cmp_count(input int got, input int exp);
      nCompared++;
      if (got < exp - 4 || got > exp + 4) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regWrEn = 1'b1;
      regAddr = a;
      regWrData = d;
      @(posedge clk);
      #1 regWrEn = 1'b0;
      // Idle edge: the next write never raises the strobe in this time step
      @(posedge clk);
      #1;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      regAddr = a;
      repeat (2) @(posedge clk);
      #1 cmp_byte(regRdData, exp);
   endtask
   function automatic logic [7:0] ref_of(input int ch);
      case (ch)
         0: return refCode0;
         1: return refCode1;
         2: return refCode2;
         default: return refCode3;
      endcase
   endfunction
   task automatic conclude();
      $display("errors %0d nCompared %0d", errors, nCompared);
      if (errors == 0 && nCompared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Reset values, read-only bits and an unmapped address
   task automatic t_regs();
      logic [7:0] addrs [6] = '{8'h08, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14};
      foreach (addrs[i]) rd_chk(addrs[i], 8'h00);
      wr(`ORPM_ADDR_RAMP_CTRL, 8'hff);
      rd_chk(`ORPM_ADDR_RAMP_CTRL, 8'h3f);
      // Fast start off again before any low-power mode is chosen
      wr(`ORPM_ADDR_RAMP_CTRL, 8'h00);
      wr(8'h20, 8'hff);
      rd_chk(8'h20, 8'h00);
   endtask
   // Every combination of the two power mode bits, with no load drawn
   task automatic t_modes();
      logic [1:0] m;
      logic [7:0] exp;
      logic [7:0] got;
      for (int i = 0; i < 4; i++) begin
         m = 2'(i);
         exp = {4'h0, m[0] & ~m[1], m[0],
            m[0] ? (m[1] ? 2'b10 : 2'b01) : 2'b00};
         wr(`ORPM_ADDR_GLOBAL_CFG, {6'h00, m});
         got = {4'h0, biasLowPower, sectionsLowPower, powerMode};
         cmp_byte(got, exp);
      end
      // Normal mode before any heavy load or overload is applied
      wr(`ORPM_ADDR_GLOBAL_CFG, 8'h00);
   endtask
   // Raise one channel from 0 to 2, then drop it to 1 and back to 0
   task automatic t_ramp(input int ch, input logic [7:0] ctl, input bit fine,
      input int lat, input int step);
      logic [7:0] ta;
      int n;
      ta = `ORPM_ADDR_TARGET0 + 8'(2 * ch);
      wr(`ORPM_ADDR_STEP_CFG, fine ? 8'(1 << ch) : 8'h00);
      wr(`ORPM_ADDR_RAMP_CTRL, ctl);
      cmp_byte(8'(fastStartActive), 8'(ctl[4] & |ctl[3:0]));
      wr(ta, 8'h02);
      cmp_byte({7'h00, chanRamping[ch]}, 8'h01);
      for (int k = 1; k <= 2; k++) begin
         n = 0;
         while (ref_of(ch) !== 8'(k) && n < 4000) begin
            @(posedge clk);
            #1 n++;
         end
         cmp_count(n, k == 1 ? lat + step : step);
      end
      repeat (400) @(posedge clk);
      #1 cmp_byte(ref_of(ch), 8'h02);
      cmp_byte({7'h00, chanRamping[ch]}, 8'h00);
      wr(ta, 8'h01);
      cmp_byte(ref_of(ch), 8'h01);
      wr(ta, 8'h00);
      cmp_byte(ref_of(ch), 8'h00);
   endtask
   // Live state follows the valley count, the flag stays until cleared
   task automatic t_overload();
      valleySteps = 4'h8;
      chanServiced = 4'h5;
      repeat (3) @(posedge clk);
      #1 rd_chk(`ORPM_ADDR_OVL_STATE, 8'h05);
      rd_chk(`ORPM_ADDR_OVL_FLAG, 8'h05);
      valleySteps = 4'h7;
      chanServiced = 4'hf;
      repeat (3) @(posedge clk);
      #1 rd_chk(`ORPM_ADDR_OVL_STATE, 8'h00);
      rd_chk(`ORPM_ADDR_OVL_FLAG, 8'h05);
      wr(`ORPM_ADDR_OVL_STATE, 8'hff);
      rd_chk(`ORPM_ADDR_OVL_STATE, 8'h00);
      wr(`ORPM_ADDR_OVL_FLAG, 8'h01);
      rd_chk(`ORPM_ADDR_OVL_FLAG, 8'h04);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      #1 reset_n = 1'b1;
      t_regs();
      t_modes();
      t_ramp(0, 8'h31, 1'b0, 250, 62);
      t_ramp(1, 8'h12, 1'b0, 250, 125);
      t_ramp(2, 8'h10, 1'b0, 2500, 312);
      t_ramp(3, 8'h28, 1'b1, 2500, 31);
      t_overload();
      conclude();
   end
endmodule
